// >>> rtl/sat_pkg.sv
// Overview of operation
// - decrement-to-work-skip: working register gets memory minus one, skip when zero
// - skip discards the fetched next instruction, adds one dummy cycle: 2 cycles
// - set byte writes all ones to memory, flags untouched
// - set bit forces one selected memory bit high, rest and flags untouched
// - increment skip writes memory plus one back, skips on zero, no flags
// - increment-to-work-skip puts memory plus one in working register, skip on zero
// - bit set skip skips when selected bit is one, no changes
// - null skip skips when memory byte is zero, no changes
// - copy null skip copies memory to working register, skips when zero
// - bit clear skip skips when selected bit is zero, no changes
// - register subtract: work plus inverted memory plus one, flags updated
// - subtract to memory: same sum written back to memory, flags updated
// - immediate subtract: work plus inverted immediate plus one, flags updated
// - in-place swap exchanges memory nibbles, flags untouched
// - nibble exchange to work writes swapped byte to working register only
// - current-page table read: low byte to memory, high byte to latch
// - final-page table read: low byte to memory, high byte to latch
// - register xor into working register, zero flag only
// - xor to memory writes back to memory, zero flag only
// - immediate xor into working register, zero flag only
package sat_pkg;
    localparam int DATA_W = 8;
    localparam int ROM_W  = 16;
    localparam int OP_W   = 5;
    localparam logic [7:0] ALL_ONES   = 8'hff;
    localparam logic [7:0] WREG_RESET = 8'h00;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic [3:0] FLAG_RESET = 4'h0;
    // flag vector positions
    localparam int FLAG_C  = 0;
    localparam int FLAG_NB = 1;
    localparam int FLAG_Z  = 2;
    localparam int FLAG_SW = 3;

    typedef enum logic [OP_W-1:0] {
        OP_NONE      = 5'h00,
        OP_DEC_WSKIP = 5'h01,
        OP_SET_BYTE  = 5'h02,
        OP_SET_BIT   = 5'h03,
        OP_INC_SKIP  = 5'h04,
        OP_INC_WSKIP = 5'h05,
        OP_BSET_SKIP = 5'h06,
        OP_NULL_SKIP = 5'h07,
        OP_COPY_NSKP = 5'h08,
        OP_BCLR_SKIP = 5'h09,
        OP_SUB_REG   = 5'h0a,
        OP_SUB_MEM   = 5'h0b,
        OP_SUB_IMM   = 5'h0c,
        OP_SWAP_MEM  = 5'h0d,
        OP_SWAP_WORK = 5'h0e,
        OP_TBL_CUR   = 5'h0f,
        OP_TBL_FIN   = 5'h10,
        OP_XOR_REG   = 5'h11,
        OP_XOR_MEM   = 5'h12,
        OP_XOR_IMM   = 5'h13
    } sat_op_t;

    typedef enum logic [2:0] {
        ST_EXEC  = 3'b001,
        ST_TABLE = 3'b010,
        ST_DUMMY = 3'b100
    } sat_state_t;
endpackage

// >>> rtl/sat_alu.sv
`timescale 1ns/1ps
module sat_alu
    import sat_pkg::*;
(
    input  wire logic [DATA_W-1:0] work_i,     // working register
    input  wire logic [DATA_W-1:0] opnd_i,     // memory or immediate operand
    output logic      [DATA_W-1:0] diff_o,     // subtraction result
    output logic                   carry_o,    // set when no borrow
    output logic                   nibble_o,   // nibble carry
    output logic                   wrap_o      // signed overflow
);
    logic [4:0]        low_sum;
    logic [DATA_W:0]   full_sum;
    logic [DATA_W-1:0] inv;

    always_comb begin
        inv      = ~opnd_i;
        // subtraction as add of inverted operand plus one
        low_sum  = {1'b0, work_i[3:0]} + {1'b0, inv[3:0]} + 5'h01;
        full_sum = {1'b0, work_i} + {1'b0, inv} + 9'h001;
        diff_o   = full_sum[DATA_W-1:0];
        carry_o  = full_sum[DATA_W];
        nibble_o = low_sum[4];
        wrap_o   = (work_i[7] != opnd_i[7]) && (full_sum[7] != work_i[7]);
    end
endmodule // sat_alu

// >>> rtl/sat_exec.sv
`timescale 1ns/1ps
module sat_exec
    import sat_pkg::*;
#(
    parameter int PC_W   = 16,   // program counter width
    parameter int PAGE_W = 8     // bits of page offset given by the table pointer
)(
    input  wire logic                sys_clk_i,     // core clock
    input  wire logic                rstn_i,        // synchronous reset, active low
    input  wire logic                issue_i,       // instruction valid this cycle
    input  wire logic [OP_W-1:0]     op_i,          // decoded operation
    input  wire logic [2:0]          bit_sel_i,     // bit index for bit operations
    input  wire logic [DATA_W-1:0]   imm_i,         // immediate byte
    input  wire logic [DATA_W-1:0]   mem_rdata_i,   // addressed memory byte
    input  wire logic [PC_W-1:0]     pc_i,          // current program counter
    input  wire logic [PAGE_W-1:0]   table_pointer_i, // table pointer
    input  wire logic [ROM_W-1:0]    rom_data_i,    // table word, sampled in the cycle rom_req_o is high
    output logic                     busy_o,        // core must not issue
    output logic                     discard_o,     // drop the prefetched instruction
    output logic                     rom_req_o,     // table fetch request
    output logic      [PC_W-1:0]     rom_addr_o,    // table fetch address
    output logic                     mem_we_o,      // memory write strobe
    output logic      [DATA_W-1:0]   mem_wdata_o,   // memory write data
    output logic      [DATA_W-1:0]   working_register_o, // working register
    output logic      [DATA_W-1:0]   table_high_latch_o, // table high byte
    output logic                     signed_wrap_flag_o, // overflow flag
    output logic                     zero_flag_o,   // zero flag
    output logic                     nibble_borrow_flag_o, // half carry flag
    output logic                     carry_flag_o   // carry flag
);
    ////////////////////////////////////////////////////////////////////////////
    sat_state_t          state, next_state;
    logic [DATA_W-1:0]   wreg, next_wreg;
    logic [DATA_W-1:0]   latch, next_latch;
    logic [3:0]          flags, next_flags;
    logic                we, next_we;
    logic [DATA_W-1:0]   wdata, next_wdata;
    logic                disc, next_disc;
    logic                req, next_req;
    logic [PC_W-1:0]     raddr, next_raddr;

    logic [DATA_W-1:0]   sub_opnd, sub_res, xor_res, dec_val, inc_val, swapped;
    logic                sub_c, sub_nb, sub_sw;
    logic                skip;
    logic                sel_bit;

    sat_alu u_alu (
        .work_i   (wreg),
        .opnd_i   (sub_opnd),
        .diff_o   (sub_res),
        .carry_o  (sub_c),
        .nibble_o (sub_nb),
        .wrap_o   (sub_sw)
    );

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        sub_opnd = (op_i == OP_SUB_IMM) ? imm_i : mem_rdata_i;
        xor_res  = wreg ^ ((op_i == OP_XOR_IMM) ? imm_i : mem_rdata_i);
        dec_val  = mem_rdata_i - 8'h01;
        inc_val  = mem_rdata_i + 8'h01;
        swapped  = {mem_rdata_i[3:0], mem_rdata_i[7:4]};
        sel_bit  = mem_rdata_i[bit_sel_i];
    end

    always_comb begin
        next_state = state;
        next_wreg  = wreg;
        next_latch = latch;
        next_flags = flags;
        next_we    = 1'b0;
        next_wdata = wdata;
        next_disc  = 1'b0;
        next_req   = 1'b0;
        next_raddr = raddr;
        skip       = 1'b0;
        case (state)
            ST_EXEC: begin
                if (issue_i) begin
                    case (op_i)
                        OP_DEC_WSKIP: begin
                            next_wreg = dec_val;
                            skip      = (dec_val == 8'h00);
                        end
                        OP_SET_BYTE: begin
                            next_we    = 1'b1;
                            next_wdata = ALL_ONES;
                        end
                        OP_SET_BIT: begin
                            next_we    = 1'b1;
                            next_wdata = mem_rdata_i | (8'h01 << bit_sel_i);
                        end
                        OP_INC_SKIP: begin
                            next_we    = 1'b1;
                            next_wdata = inc_val;
                            skip       = (inc_val == 8'h00);
                        end
                        OP_INC_WSKIP: begin
                            next_wreg = inc_val;
                            skip      = (inc_val == 8'h00);
                        end
                        OP_BSET_SKIP: begin
                            skip = sel_bit;
                        end
                        OP_NULL_SKIP: begin
                            skip = (mem_rdata_i == 8'h00);
                        end
                        OP_COPY_NSKP: begin
                            next_wreg = mem_rdata_i;
                            skip      = (mem_rdata_i == 8'h00);
                        end
                        OP_BCLR_SKIP: begin
                            skip = !sel_bit;
                        end
                        OP_SUB_REG, OP_SUB_IMM, OP_SUB_MEM: begin
                            if (op_i == OP_SUB_MEM) begin
                                next_we    = 1'b1;
                                next_wdata = sub_res;
                            end else begin
                                next_wreg = sub_res;
                            end
                            next_flags[FLAG_SW] = sub_sw;
                            next_flags[FLAG_Z]  = (sub_res == 8'h00);
                            next_flags[FLAG_NB] = sub_nb;
                            next_flags[FLAG_C]  = sub_c;
                        end
                        OP_SWAP_MEM: begin
                            next_we    = 1'b1;
                            next_wdata = swapped;
                        end
                        OP_SWAP_WORK: begin
                            next_wreg = swapped;
                        end
                        OP_TBL_CUR: begin
                            // page bits from the program counter, offset from the pointer
                            next_raddr = {pc_i[PC_W-1:PAGE_W], table_pointer_i};
                            next_req   = 1'b1;
                            next_state = ST_TABLE;
                        end
                        OP_TBL_FIN: begin
                            next_raddr = {{(PC_W-PAGE_W){1'b1}}, table_pointer_i};
                            next_req   = 1'b1;
                            next_state = ST_TABLE;
                        end
                        OP_XOR_REG, OP_XOR_IMM: begin
                            next_wreg          = xor_res;
                            next_flags[FLAG_Z] = (xor_res == 8'h00);
                        end
                        OP_XOR_MEM: begin
                            next_we            = 1'b1;
                            next_wdata         = xor_res;
                            next_flags[FLAG_Z] = (xor_res == 8'h00);
                        end
                        default: begin
                        end
                    endcase
                    if (skip) begin
                        // fetched follower is flushed, one dummy cycle follows
                        next_disc  = 1'b1;
                        next_state = ST_DUMMY;
                    end
                end
            end
            ST_TABLE: begin
                // table reads cost a second cycle while the rom answers
                next_we    = 1'b1;
                next_wdata = rom_data_i[DATA_W-1:0];
                next_latch = rom_data_i[ROM_W-1:DATA_W];
                next_state = ST_EXEC;
            end
            ST_DUMMY: begin
                next_state = ST_EXEC;
            end
            default: begin
                next_state = ST_EXEC;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            state <= ST_EXEC;
            wreg  <= WREG_RESET;
            latch <= LATCH_RESET;
            flags <= FLAG_RESET;
            we    <= 1'b0;
            wdata <= 8'h00;
            disc  <= 1'b0;
            req   <= 1'b0;
            raddr <= '0;
        end else begin
            state <= next_state;
            wreg  <= next_wreg;
            latch <= next_latch;
            flags <= next_flags;
            we    <= next_we;
            wdata <= next_wdata;
            disc  <= next_disc;
            req   <= next_req;
            raddr <= next_raddr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        busy_o               = (state != ST_EXEC);
        discard_o            = disc;
        rom_req_o            = req;
        rom_addr_o           = raddr;
        mem_we_o             = we;
        mem_wdata_o          = wdata;
        working_register_o   = wreg;
        table_high_latch_o   = latch;
        signed_wrap_flag_o   = flags[FLAG_SW];
        zero_flag_o          = flags[FLAG_Z];
        nibble_borrow_flag_o = flags[FLAG_NB];
        carry_flag_o         = flags[FLAG_C];
    end
endmodule // sat_exec

// >>> sim/sat_exec_chk.sv
`timescale 1ns/1ps
module sat_exec_chk
    import sat_pkg::*;
(
    input wire logic              sys_clk_i,          // clock
    input wire logic              rstn_i,             // reset
    input wire logic              issue_i,            // issue
    input wire logic [OP_W-1:0]   op_i,               // operation
    input wire logic [2:0]        bit_sel_i,          // bit index
    input wire logic [DATA_W-1:0] mem_rdata_i,        // memory byte
    input wire logic [ROM_W-1:0]  rom_data_i,         // table word
    input wire logic              busy_o,             // busy
    input wire logic              discard_o,          // drop prefetch
    input wire logic              rom_req_o,          // table fetch
    input wire logic              mem_we_o,           // memory write
    input wire logic [DATA_W-1:0] mem_wdata_o,        // write data
    input wire logic [DATA_W-1:0] working_register_o, // working register
    input wire logic [DATA_W-1:0] table_high_latch_o, // table high byte
    input wire logic              zero_flag_o,        // zero flag
    input wire logic              carry_flag_o        // carry flag
);
    logic        take;
    logic [7:0]  md_q;
    logic [2:0]  bs_q;
    logic [15:0] rd_q;
    assign take = issue_i && !busy_o;
    // operands held one cycle so a result can be judged against what was taken
    always_ff @(posedge sys_clk_i) begin
        md_q <= mem_rdata_i;
        bs_q <= bit_sel_i;
        rd_q <= rom_data_i;
    end
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rstn_i);
////////////////////////////////////////////////////////////////////////////////
    a_null_skip_dummy: assert property (
        take && op_i == OP_NULL_SKIP && mem_rdata_i == 8'h00 |=> discard_o && busy_o ##1 !busy_o)
        else $error("null skip missed its dummy cycle");
    a_dec_work_copy: assert property (
        take && op_i == OP_DEC_WSKIP |=> working_register_o == md_q - 8'h01 && !mem_we_o && discard_o == (md_q == 8'h01))
        else $error("decrement to work result or skip wrong");
    a_set_byte_ones: assert property (
        take && op_i == OP_SET_BYTE |=> mem_we_o && mem_wdata_o == ALL_ONES && $stable(zero_flag_o) && $stable(carry_flag_o))
        else $error("set byte wrong");
    a_set_bit_one: assert property (
        take && op_i == OP_SET_BIT |=> mem_we_o && mem_wdata_o == (md_q | (8'h01 << bs_q)))
        else $error("set bit wrong");
    a_swap_work_only: assert property (
        take && op_i == OP_SWAP_WORK |=> working_register_o == {md_q[3:0], md_q[7:4]} && !mem_we_o)
        else $error("nibble exchange to work wrong");
    a_table_pair: assert property (
        take && (op_i == OP_TBL_CUR || op_i == OP_TBL_FIN) |=> rom_req_o && busy_o
        ##1 mem_we_o && mem_wdata_o == rd_q[7:0] && table_high_latch_o == rd_q[15:8])
        else $error("table word not split to memory and latch");
    a_xor_zero_only: assert property (
        take && op_i == OP_XOR_REG |=> working_register_o == ($past(working_register_o) ^ md_q)
        && zero_flag_o == (working_register_o == 8'h00) && $stable(carry_flag_o))
        else $error("register xor wrong");
    a_sub_no_borrow: assert property (
        take && op_i == OP_SUB_REG |=> carry_flag_o == ($past(working_register_o) >= md_q))
        else $error("subtract carry wrong");
    c_table_final: cover property (take && op_i == OP_TBL_FIN);
    c_skip_refused: cover property (discard_o && issue_i);
    c_sub_memory: cover property (take && op_i == OP_SUB_MEM);
endmodule // sat_exec_chk
////////////////////////////////////////////////////////////////////////////////
bind sat_exec sat_exec_chk u_sat_exec_chk (
    .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .issue_i(issue_i), .op_i(op_i), .bit_sel_i(bit_sel_i),
    .mem_rdata_i(mem_rdata_i), .rom_data_i(rom_data_i), .busy_o(busy_o), .discard_o(discard_o),
    .rom_req_o(rom_req_o), .mem_we_o(mem_we_o), .mem_wdata_o(mem_wdata_o), .working_register_o(working_register_o),
    .table_high_latch_o(table_high_latch_o), .zero_flag_o(zero_flag_o), .carry_flag_o(carry_flag_o)
);

// >>> sim/sat_exec_tb_top.sv
`timescale 1ns/1ps
module sat_exec_tb_top;
    import sat_pkg::*;
    logic            sys_clk_i = 1'b0, rstn_i = 1'b0, issue_i = 1'b0;
    logic [OP_W-1:0] op_i = '0;
    logic [2:0]      bit_sel_i = 3'h0;
    logic [7:0]      imm_i = 8'h00, mem_rdata_i = 8'h00, table_pointer_i = 8'h00, wreg, wdata, latch;
    logic [15:0]     pc_i = 16'h3a77, rom_data_i = 16'h0000, raddr;
    logic            busy, discard, rom_req, mem_we, f_sw, f_z, f_nb, f_c;
    logic [7:0]      w_x = 8'h00;
    logic [3:0]      f_x = 4'h0;
    int              miscompares = 0, cmp_count = 0;
    always #25 sys_clk_i = ~sys_clk_i;
    sat_exec u_sat_exec (
        .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .issue_i(issue_i), .op_i(op_i), .bit_sel_i(bit_sel_i),
        .imm_i(imm_i), .mem_rdata_i(mem_rdata_i), .pc_i(pc_i), .table_pointer_i(table_pointer_i),
        .rom_data_i(rom_data_i), .busy_o(busy), .discard_o(discard), .rom_req_o(rom_req), .rom_addr_o(raddr),
        .mem_we_o(mem_we), .mem_wdata_o(wdata), .working_register_o(wreg), .table_high_latch_o(latch),
        .signed_wrap_flag_o(f_sw), .zero_flag_o(f_z), .nibble_borrow_flag_o(f_nb), .carry_flag_o(f_c)
    );
////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // issue is left high so the next op follows back to back; a skip keeps issuing into the dummy cycle
    task automatic st(input sat_op_t op, input logic [2:0] bs, input logic [7:0] im, input logic [7:0] md,
                      input logic we, input logic [7:0] wd, input logic sk);
        issue_i = 1'b1;
        op_i = op;
        bit_sel_i = bs;
        imm_i = im;
        mem_rdata_i = md;
        @(negedge sys_clk_i);
        if (sk) op_i = OP_SET_BYTE;
        chk(wreg, w_x);
        chk({f_sw, f_z, f_nb, f_c}, f_x);
        chk(mem_we, we);
        if (we) chk(wdata, wd);
        chk(discard, sk);
        chk(busy, sk);
        if (sk) begin
            @(negedge sys_clk_i);
            chk(busy, 1'b0);
            chk(mem_we, 1'b0);
        end
    endtask
    task automatic t_alu(input sat_op_t op, input logic [7:0] w, input logic [7:0] m);
        logic [8:0] s;
        logic [4:0] h;
        logic       sub, mem, imm;
        sub = op inside {OP_SUB_REG, OP_SUB_MEM, OP_SUB_IMM};
        mem = op inside {OP_SUB_MEM, OP_XOR_MEM};
        imm = op inside {OP_SUB_IMM, OP_XOR_IMM};
        s = {1'b0, w} + {1'b0, ~m} + 9'h001;
        h = {1'b0, w[3:0]} + {1'b0, ~m[3:0]} + 5'h01;
        if (!sub) s = {1'b0, w ^ m};
        w_x = w;
        st(OP_COPY_NSKP, 3'h0, 8'h00, w, 1'b0, 8'h00, 1'b0);
        if (sub) f_x = {(w[7] != m[7]) && (s[7] != w[7]), 1'b0, h[4], s[8]};
        f_x[FLAG_Z] = s[7:0] == 8'h00;
        if (!mem) w_x = s[7:0];
        st(op, 3'h0, imm ? m : ~m, imm ? ~m : m, mem, s[7:0], 1'b0);
        $display("alu test done");
    endtask
    task automatic t_mem();
        w_x = 8'h00;
        st(OP_DEC_WSKIP, 3'h0, 8'h00, 8'h01, 1'b0, 8'h00, 1'b1);
        w_x = 8'hff;
        st(OP_DEC_WSKIP, 3'h0, 8'h00, 8'h00, 1'b0, 8'h00, 1'b0);
        st(OP_INC_SKIP, 3'h0, 8'h00, 8'hff, 1'b1, 8'h00, 1'b1);
        st(OP_INC_SKIP, 3'h0, 8'h00, 8'h7f, 1'b1, 8'h80, 1'b0);
        w_x = 8'h00;
        st(OP_INC_WSKIP, 3'h0, 8'h00, 8'hff, 1'b0, 8'h00, 1'b1);
        w_x = 8'h11;
        st(OP_INC_WSKIP, 3'h0, 8'h00, 8'h10, 1'b0, 8'h00, 1'b0);
        st(OP_BSET_SKIP, 3'h7, 8'h00, 8'h80, 1'b0, 8'h00, 1'b1);
        st(OP_BSET_SKIP, 3'h0, 8'h00, 8'hfe, 1'b0, 8'h00, 1'b0);
        st(OP_NULL_SKIP, 3'h0, 8'h00, 8'h00, 1'b0, 8'h00, 1'b1);
        st(OP_NULL_SKIP, 3'h0, 8'h00, 8'h01, 1'b0, 8'h00, 1'b0);
        w_x = 8'h00;
        st(OP_COPY_NSKP, 3'h0, 8'h00, 8'h00, 1'b0, 8'h00, 1'b1);
        st(OP_BCLR_SKIP, 3'h3, 8'h00, 8'hf7, 1'b0, 8'h00, 1'b1);
        st(OP_BCLR_SKIP, 3'h3, 8'h00, 8'h08, 1'b0, 8'h00, 1'b0);
        st(OP_SET_BYTE, 3'h0, 8'h00, 8'h12, 1'b1, 8'hff, 1'b0);
        st(OP_SET_BIT, 3'h5, 8'h00, 8'h01, 1'b1, 8'h21, 1'b0);
        st(OP_SWAP_MEM, 3'h0, 8'h00, 8'ha5, 1'b1, 8'h5a, 1'b0);
        w_x = 8'h3c;
        st(OP_SWAP_WORK, 3'h0, 8'h00, 8'hc3, 1'b0, 8'h00, 1'b0);
        $display("skip and set test done");
    endtask
    task automatic t_tbl(input sat_op_t op, input logic [7:0] ptr, input logic [15:0] word, input logic [15:0] addr);
        issue_i = 1'b1;
        op_i = op;
        table_pointer_i = ptr;
        @(negedge sys_clk_i);
        op_i = OP_SET_BYTE;
        rom_data_i = word;
        chk(rom_req, 1'b1);
        chk(raddr, addr);
        chk(busy, 1'b1);
        @(negedge sys_clk_i);
        rom_data_i = ~word;
        chk(rom_req, 1'b0);
        chk(mem_we, 1'b1);
        chk(wdata, word[7:0]);
        chk(latch, word[15:8]);
        chk(busy, 1'b0);
        $display("table read test done");
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(negedge sys_clk_i);
        rstn_i = 1'b1;
        chk(wreg, WREG_RESET);
        chk(latch, LATCH_RESET);
        chk({f_sw, f_z, f_nb, f_c}, FLAG_RESET);
        t_alu(OP_XOR_REG, 8'h5a, 8'h5a);
        t_alu(OP_XOR_MEM, 8'hf0, 8'h3c);
        t_alu(OP_XOR_IMM, 8'h33, 8'h99);
        t_alu(OP_SUB_MEM, 8'h05, 8'h05);
        t_alu(OP_SUB_IMM, 8'h10, 8'h21);
        t_alu(OP_SUB_REG, 8'h80, 8'h01);
        t_mem();
        t_tbl(OP_TBL_CUR, 8'h05, 16'hbeef, 16'h3a05);
        t_tbl(OP_TBL_FIN, 8'hc3, 16'h1234, 16'hffc3);
        // reset again with non-zero latch, flags and working register: all must return to rest
        issue_i = 1'b0;
        rstn_i = 1'b0;
        @(negedge sys_clk_i);
        chk(wreg, WREG_RESET);
        chk(latch, LATCH_RESET);
        chk({f_sw, f_z, f_nb, f_c}, FLAG_RESET);
        chk({busy, discard, rom_req, mem_we}, 16'h0000);
        rstn_i = 1'b1;
        $display("reset test done");
        close_out();
    end
    initial begin
        #100000;
        miscompares++;
        close_out();
    end
endmodule // sat_exec_tb_top
